// ### verilog/tcg_regs.vh
`ifndef TCG_REGS_VH
`define TCG_REGS_VH
`define TCG_CLK_HZ 200000000
`define TCG_TICK_MS 100
`define TCG_TICK_CYC (`TCG_CLK_HZ / 1000 * `TCG_TICK_MS)
`define TCG_HOLD_MAX 8'h50
`define TCG_HOLD_DEF 8'h14
`define TCG_MODE_OFF 4'h0
`define TCG_MODE_FREE 4'h1
`define TCG_MODE_RECRUN 4'h2
`define TCG_MODE_JAMONCE 4'h3
`define TCG_MODE_TOD 4'h4
`define TCG_MODE_EXT 4'h5
`define TCG_MODE_EXTC 4'h6
`define TCG_MODE_EXTREC 4'h7
`define TCG_MODE_EXTRECC 4'h8
`define TCG_MODE_MUTE 4'h9
`define TCG_UB_MODES 3'h7
`define TCG_MAX_H 5'h17
`define TCG_MAX_MS 6'h3B
`endif

// ### verilog/tcg_core.v
`timescale 1ns/100ps
`include "tcg_regs.vh"
module tcg_core #(
  parameter TICK_CYC = `TCG_TICK_CYC
) (
  // Clock and reset.
  input wire CLK_I,
  input wire SYS_RST_I,
  // Register port.
  input wire [3:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [31:0] RDATA_O,
  // Time code input side, from the link receiver.
  input wire RX_VALID_I,
  input wire RX_FRAME_I,
  input wire [23:0] RX_TIME_I,
  input wire [4:0] RX_FRAME_NUM_I,
  input wire [3:0] RX_RATE_I,
  // Time code clock frame tick and time-of-day clock.
  input wire TC_TICK_I,
  input wire [23:0] TOD_TIME_I,
  input wire TOD_RESET_I,
  // Transport.
  input wire PLAYING_I,
  input wire PRE_ROLL_I,
  // Outputs.
  output reg [28:0] GEN_TIME_O,
  output reg GEN_BLANK_O,
  output reg TC_OUT_EN_O,
  output reg [3:0] FILE_RATE_O,
  output reg RX_INVALID_O,
  output reg REC_PENDING_O,
  output reg REC_START_O,
  output reg RECORD_O,
  output reg CAPTURE_FROM_DETECT_O,
  output reg [31:0] USER_BITS_O
);
  // Registers: 0 mode, 1 rate(fps-1,bit5 drop), 2 hold, 3 edit, 4 command,
  // 5 user-bit mode, 6 user edit, 7 status.
  reg [3:0] mode_q;
  reg [4:0] fps_q;
  reg drop_q;
  reg [7:0] hold_q;
  reg [28:0] edit_q;
  reg [2:0] ub_mode_q;
  reg [31:0] ub_edit_q;
  reg jam_rx_q, jam_zero_q, jam_val_q;
  // Synchronisers for asynchronous pins.
  reg [1:0] rxv_s, rxf_s, tick_s, todr_s, play_s, pre_s;
  reg rxf_d1_q, tick_d1_q, todr_d1_q;
  // Code words and time of day pass two stages, like their strobes.
  reg [32:0] rxd_a_q, rxd_b_q;
  reg [23:0] tod_a_q, tod_b_q;
  reg tod_loaded_q;
  reg [4:0] fr_q;
  reg [5:0] se_q, mi_q;
  reg [4:0] hr_q;
  reg [28:0] last_rx_q;
  reg advancing_q;
  reg [24:0] adv_cnt_q;
  reg [24:0] tick_cnt_q;
  reg [7:0] hold_cnt_q;
  reg pend_q, rec_q;
  wire ext_mode = (mode_q >= `TCG_MODE_EXT) && (mode_q <= `TCG_MODE_EXTRECC);
  wire cont_mode = (mode_q == `TCG_MODE_EXTC) ||
    (mode_q == `TCG_MODE_EXTRECC);
  wire trig_mode = (mode_q == `TCG_MODE_EXTREC) ||
    (mode_q == `TCG_MODE_EXTRECC);
  wire rx_ok = rxv_s[1];
  wire rx_frame = rxf_s[1] & ~rxf_d1_q;
  wire tc_tick = tick_s[1] & ~tick_d1_q;
  wire tod_rst = todr_s[1] & ~todr_d1_q;
  wire [28:0] rx_val = rxd_b_q[28:0];
  wire rate_match = (rxd_b_q[32:29] == {drop_q, fps_q[2:0]});
  wire [28:0] gen_val = {hr_q, 2'h0, mi_q, 2'h0, se_q, 3'h0, fr_q};
  wire ub_editable = (ub_mode_q == 3'h0) || (ub_mode_q == 3'h6);
  wire wr_edit_ok = (WDATA_I[28:24] <= `TCG_MAX_H) &&
    (WDATA_I[21:16] <= `TCG_MAX_MS) && (WDATA_I[13:8] <= `TCG_MAX_MS) &&
    (WDATA_I[4:0] <= 5'h1D);
  reg run_en;
  always @* begin
    case (mode_q)
      `TCG_MODE_OFF: run_en = 1'b0;
      `TCG_MODE_RECRUN: run_en = rec_q;
      `TCG_MODE_EXTREC: run_en = rec_q;
      // Stationary code never ticks here; only lost code lets it run on.
      `TCG_MODE_EXTRECC: run_en = 1'b1;
      default: run_en = 1'b1;
    endcase
  end
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rxv_s <= 2'h0; rxf_s <= 2'h0; tick_s <= 2'h0;
      todr_s <= 2'h0; play_s <= 2'h0; pre_s <= 2'h0;
      rxf_d1_q <= 1'b0; tick_d1_q <= 1'b0; todr_d1_q <= 1'b0;
      rxd_a_q <= 33'h0; rxd_b_q <= 33'h0;
      tod_a_q <= 24'h0; tod_b_q <= 24'h0;
    end else begin
      rxv_s <= {rxv_s[0], RX_VALID_I};
      rxf_s <= {rxf_s[0], RX_FRAME_I};
      tick_s <= {tick_s[0], TC_TICK_I};
      todr_s <= {todr_s[0], TOD_RESET_I};
      play_s <= {play_s[0], PLAYING_I};
      pre_s <= {pre_s[0], PRE_ROLL_I};
      rxf_d1_q <= rxf_s[1];
      tick_d1_q <= tick_s[1];
      todr_d1_q <= todr_s[1];
      rxd_a_q <= {RX_RATE_I, RX_TIME_I, RX_FRAME_NUM_I};
      rxd_b_q <= rxd_a_q;
      tod_a_q <= TOD_TIME_I;
      tod_b_q <= tod_a_q;
    end
  end
  // Register writes; jam commands are one-shot and self-clear.
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      mode_q <= `TCG_MODE_OFF;
      fps_q <= 5'h1D;
      drop_q <= 1'b0;
      hold_q <= `TCG_HOLD_DEF;
      edit_q <= 29'h0;
      ub_mode_q <= 3'h0;
      ub_edit_q <= 32'h0;
      jam_rx_q <= 1'b0; jam_zero_q <= 1'b0; jam_val_q <= 1'b0;
    end else begin
      jam_zero_q <= WR_I && ADDR_I == 4'h4 && WDATA_I[1];
      jam_val_q <= WR_I && ADDR_I == 4'h4 && WDATA_I[2];
      if (WR_I && ADDR_I == 4'h4 && WDATA_I[0])
        jam_rx_q <= 1'b1;
      else if (jam_rx_q && (!rx_ok || (rx_frame && (rate_match ||
               rx_val[4:0] == 5'h00))))
        jam_rx_q <= 1'b0;
      if (WR_I) begin
        case (ADDR_I)
          4'h0: mode_q <= WDATA_I[3:0];
          4'h1: begin
            fps_q <= WDATA_I[4:0];
            drop_q <= WDATA_I[5];
          end
          4'h2: if (WDATA_I[7:0] <= `TCG_HOLD_MAX)
            hold_q <= WDATA_I[7:0];
          4'h3: if (wr_edit_ok)
            edit_q <= WDATA_I[28:0];
          4'h5: if (WDATA_I[2:0] < `TCG_UB_MODES)
            ub_mode_q <= WDATA_I[2:0];
          4'h6: if (ub_editable)
            ub_edit_q <= WDATA_I;
          default: ;
        endcase
      end
    end
  end
  // Generator counter with drop-frame skip.
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      fr_q <= 5'h0; se_q <= 6'h0; mi_q <= 6'h0; hr_q <= 5'h0;
      tod_loaded_q <= 1'b0;
    end else if (jam_zero_q) begin
      fr_q <= 5'h0; se_q <= 6'h0; mi_q <= 6'h0; hr_q <= 5'h0;
    end else if (jam_val_q) begin
      hr_q <= edit_q[28:24]; mi_q <= edit_q[21:16];
      se_q <= edit_q[13:8]; fr_q <= edit_q[4:0];
    end else if (jam_rx_q && rx_ok && rx_frame &&
                 (rate_match || rx_val[4:0] == 5'h00)) begin
      hr_q <= rx_val[28:24]; mi_q <= rx_val[21:16];
      se_q <= rx_val[13:8]; fr_q <= rx_val[4:0];
    end else if (ext_mode && rx_ok && rx_frame) begin
      hr_q <= rx_val[28:24]; mi_q <= rx_val[21:16];
      se_q <= rx_val[13:8]; fr_q <= rx_val[4:0];
    end else if (mode_q == `TCG_MODE_TOD &&
                 (!tod_loaded_q || tod_rst)) begin
      tod_loaded_q <= 1'b1;
      hr_q <= tod_b_q[23:19]; mi_q <= tod_b_q[16:11];
      se_q <= tod_b_q[8:3]; fr_q <= 5'h0;
    end else if (tc_tick && run_en &&
                 (!ext_mode || (cont_mode && !rx_ok))) begin
      if (fr_q < fps_q) begin
        fr_q <= fr_q + 5'h1;
      end else begin
        if (se_q < `TCG_MAX_MS) begin
          se_q <= se_q + 6'h1;
          fr_q <= 5'h0;
        end else begin
          se_q <= 6'h0;
          if (mi_q < `TCG_MAX_MS) begin
            mi_q <= mi_q + 6'h1;
            fr_q <= (drop_q && ((mi_q + 6'h1) % 6'hA != 6'h0)) ?
              5'h2 : 5'h0;
          end else begin
            mi_q <= 6'h0;
            fr_q <= 5'h0;
            hr_q <= (hr_q < `TCG_MAX_H) ? hr_q + 5'h1 : 5'h0;
          end
        end
      end
    end
  end
  // Advance detector: code counts as moving if it changed within a tick.
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      last_rx_q <= 29'h0;
      advancing_q <= 1'b0;
      adv_cnt_q <= 25'h0;
    end else if (!rx_ok) begin
      advancing_q <= 1'b0;
      adv_cnt_q <= 25'h0;
    end else if (rx_frame) begin
      last_rx_q <= rx_val;
      if (rx_val != last_rx_q) begin
        advancing_q <= 1'b1;
        adv_cnt_q <= 25'h0;
      end
    end else if (adv_cnt_q >= TICK_CYC[24:0]) begin
      advancing_q <= 1'b0;
    end else begin
      adv_cnt_q <= adv_cnt_q + 25'h1;
    end
  end
  // Hold-off and auto record.
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      tick_cnt_q <= 25'h0; hold_cnt_q <= 8'h0;
      pend_q <= 1'b0; rec_q <= 1'b0;
    end else if (!trig_mode) begin
      pend_q <= 1'b0; rec_q <= 1'b0;
      tick_cnt_q <= 25'h0; hold_cnt_q <= 8'h0;
    end else if (!advancing_q) begin
      pend_q <= 1'b0; rec_q <= 1'b0;
    end else if (!pend_q && !rec_q) begin
      pend_q <= 1'b1;
      tick_cnt_q <= 25'h0; hold_cnt_q <= 8'h0;
    end else if (pend_q) begin
      if (hold_cnt_q >= hold_q) begin
        pend_q <= 1'b0; rec_q <= 1'b1;
      end else if (tick_cnt_q >= TICK_CYC[24:0] - 25'h1) begin
        tick_cnt_q <= 25'h0;
        hold_cnt_q <= hold_cnt_q + 8'h1;
      end else begin
        tick_cnt_q <= tick_cnt_q + 25'h1;
      end
    end
  end
  // Outputs and read data.
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      RDATA_O <= 32'h0; GEN_TIME_O <= 29'h0; GEN_BLANK_O <= 1'b1;
      TC_OUT_EN_O <= 1'b0; FILE_RATE_O <= 4'h0; RX_INVALID_O <= 1'b1;
      REC_PENDING_O <= 1'b0; REC_START_O <= 1'b0; RECORD_O <= 1'b0;
      CAPTURE_FROM_DETECT_O <= 1'b0; USER_BITS_O <= 32'h0;
    end else begin
      GEN_TIME_O <= gen_val;
      GEN_BLANK_O <= (mode_q == `TCG_MODE_OFF);
      TC_OUT_EN_O <= (mode_q == `TCG_MODE_MUTE) ?
        (rec_q || play_s[1]) : (mode_q != `TCG_MODE_OFF);
      FILE_RATE_O <= {drop_q, fps_q[2:0]};
      RX_INVALID_O <= !rx_ok;
      REC_PENDING_O <= pend_q;
      REC_START_O <= pend_q && hold_cnt_q >= hold_q && advancing_q;
      RECORD_O <= rec_q;
      CAPTURE_FROM_DETECT_O <= pre_s[1] && (pend_q || rec_q);
      USER_BITS_O <= ub_editable ? ub_edit_q :
        {ub_mode_q, 5'h0, gen_val[28:5]};
      RDATA_O <= 32'h0;
      if (RD_I) begin
        case (ADDR_I)
          4'h0: RDATA_O <= {28'h0, mode_q};
          4'h1: RDATA_O <= {26'h0, drop_q, fps_q};
          4'h2: RDATA_O <= {24'h0, hold_q};
          4'h3: RDATA_O <= {3'h0, edit_q};
          4'h5: RDATA_O <= {29'h0, ub_mode_q};
          4'h6: RDATA_O <= ub_edit_q;
          4'h7: RDATA_O <= {rx_ok ? 3'h0 : 3'h1, gen_val};
          default: RDATA_O <= 32'h0;
        endcase
      end
    end
  end
endmodule // tcg_core

// ### dv/tcg_core_monitor.sv
`timescale 1ns/100ps
module tcg_core_monitor #(
  parameter TICK_CYC = 50
) (
  // Clock, reset and register writes.
  input wire CLK_I,
  input wire SYS_RST_I,
  input wire [3:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  // Code and transport inputs.
  input wire RX_VALID_I,
  input wire PLAYING_I,
  // Watched outputs.
  input wire [28:0] GEN_TIME_O,
  input wire GEN_BLANK_O,
  input wire TC_OUT_EN_O,
  input wire RX_INVALID_O,
  input wire REC_PENDING_O,
  input wire REC_START_O,
  input wire RECORD_O
);
  // An unknown mode is held as 4'hF so no mode check fires before setup.
  reg [3:0] mode_q;
  reg [7:0] hold_q;
  reg [31:0] pend_q;
  wire auto_w = (mode_q == 4'h7) || (mode_q == 4'h8);
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      mode_q <= 4'hF;
      hold_q <= 8'h14;
      pend_q <= 32'h0;
    end else begin
      if (WR_I && ADDR_I == 4'h0)
        mode_q <= WDATA_I[3:0];
      if (WR_I && ADDR_I == 4'h2 && WDATA_I[7:0] <= 8'h50)
        hold_q <= WDATA_I[7:0];
      pend_q <= REC_PENDING_O ? pend_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  AST_PEND_MODE: assert property ((!auto_w && mode_q <= 4'h9) [*4]
    |-> !REC_PENDING_O && !RECORD_O) else $error("pending outside auto");
  AST_START_PEND: assert property (REC_START_O
    |-> $past(REC_PENDING_O)) else $error("start without pending");
  AST_HOLD_TIME: assert property ($rose(RECORD_O)
    |-> pend_q + 32'h3 >= hold_q * TICK_CYC) else $error("hold cut short");
  AST_LOSS_STOP: assert property (!RX_VALID_I [*6]
    |-> !REC_PENDING_O && !RECORD_O) else $error("record kept on loss");
  AST_MUTE_OFF: assert property (
    (mode_q == 4'h9 && !PLAYING_I && !RECORD_O) [*5] |-> !TC_OUT_EN_O)
    else $error("output not muted");
  AST_MUTE_ON: assert property ((mode_q == 4'h9 && PLAYING_I) [*5]
    |-> TC_OUT_EN_O) else $error("output muted in playback");
  AST_OFF_BLANK: assert property ((mode_q == 4'h0) [*3]
    |-> GEN_BLANK_O) else $error("display not blank");
  AST_INVALID: assert property (!RX_VALID_I [*5]
    |-> RX_INVALID_O) else $error("invalid flag missing");
  AST_ZEROS: assert property (
    WR_I && ADDR_I == 4'h4 && WDATA_I[2:0] == 3'h2 && mode_q == 4'h1
    |-> ##[1:4] GEN_TIME_O == 29'h0) else $error("zeros jam missing");
  cover property ($rose(RECORD_O));
  cover property (REC_PENDING_O && !RX_VALID_I);
  cover property (mode_q == 4'h9 && TC_OUT_EN_O);
endmodule // tcg_core_monitor
bind tcg_core tcg_core_monitor #(.TICK_CYC(TICK_CYC)) u_tcg_core_monitor (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RX_VALID_I(RX_VALID_I), .PLAYING_I(PLAYING_I),
  .GEN_TIME_O(GEN_TIME_O), .GEN_BLANK_O(GEN_BLANK_O),
  .TC_OUT_EN_O(TC_OUT_EN_O), .RX_INVALID_O(RX_INVALID_O),
  .REC_PENDING_O(REC_PENDING_O), .REC_START_O(REC_START_O),
  .RECORD_O(RECORD_O));

// ### dv/tcg_src_model.sv
`timescale 1ns/100ps
module tcg_src_model #(
  parameter FR_CYC = 20
) (
  // Clock and controls.
  input wire clk_i,
  input wire rst_i,
  input wire present_i,
  input wire run_i,
  input wire [3:0] rate_i,
  // Code toward the device.
  output reg valid_o,
  output reg frame_o,
  output reg [23:0] time_o,
  output reg [4:0] fnum_o,
  output reg [3:0] rate_o
);
  reg [7:0] div_q;
  reg [5:0] sec_q;
  reg [4:0] fr_q;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {valid_o, frame_o, time_o, fnum_o, rate_o} <= 35'h0;
      {div_q, sec_q, fr_q} <= 19'h0;
    end else if (!present_i) begin
      // A pulled cable floats, so the time and frame-number lines toggle rather than hold.
      valid_o <= 1'b0;
      frame_o <= 1'b0;
      time_o <= ~time_o;
      fnum_o <= ~fnum_o;
    end else begin
      valid_o <= 1'b1;
      rate_o <= rate_i;
      div_q <= (div_q == FR_CYC - 1) ? 8'h0 : div_q + 8'h1;
      frame_o <= (div_q == 8'h0);
      time_o <= {15'h0, sec_q, 3'h0};
      fnum_o <= fr_q;
      // Advance just before the strobe so a frame stays put while stopped.
      if (div_q == FR_CYC - 1 && run_i) begin
        fr_q <= (fr_q == 5'h1D) ? 5'h0 : fr_q + 5'h1;
        if (fr_q == 5'h1D)
          sec_q <= (sec_q == 6'h3B) ? 6'h0 : sec_q + 6'h1;
      end
    end
  end
endmodule // tcg_src_model

// ### dv/tcg_core_test.sv
`timescale 1ns/100ps
module tcg_core_test;
  reg clk, rst, wr_st, rd_st, tick, tod_rst, playing, pre_roll, present, run;
  reg [3:0] addr;
  reg [31:0] wdata, d, v;
  reg [23:0] tod;
  wire [31:0] rdata, ub;
  wire [28:0] gen;
  wire [23:0] rx_time;
  wire [4:0] rx_fnum;
  wire [3:0] rx_rate, frate;
  wire rx_valid, rx_frame, blank, out_en, rx_inv, pend, start, rec, cap;
  int error_cnt, compares, cyc, i;
  tcg_core #(.TICK_CYC(50)) u_tcg_core (.CLK_I(clk), .SYS_RST_I(rst),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_st), .RD_I(rd_st),
    .RDATA_O(rdata), .RX_VALID_I(rx_valid), .RX_FRAME_I(rx_frame),
    .RX_TIME_I(rx_time), .RX_FRAME_NUM_I(rx_fnum), .RX_RATE_I(rx_rate),
    .TC_TICK_I(tick), .TOD_TIME_I(tod), .TOD_RESET_I(tod_rst),
    .PLAYING_I(playing), .PRE_ROLL_I(pre_roll), .GEN_TIME_O(gen),
    .GEN_BLANK_O(blank), .TC_OUT_EN_O(out_en), .FILE_RATE_O(frate),
    .RX_INVALID_O(rx_inv), .REC_PENDING_O(pend), .REC_START_O(start),
    .RECORD_O(rec), .CAPTURE_FROM_DETECT_O(cap), .USER_BITS_O(ub));
  tcg_src_model #(.FR_CYC(20)) u_tcg_src_model (.clk_i(clk), .rst_i(rst),
    .present_i(present), .run_i(run), .rate_i(4'h3), .valid_o(rx_valid),
    .frame_o(rx_frame), .time_o(rx_time), .fnum_o(rx_fnum), .rate_o(rx_rate));
  function [31:0] tc(input [4:0] h, input [5:0] m, input [5:0] s,
                     input [4:0] f);
    tc = {3'h0, h, 2'h0, m, 2'h0, s, 3'h0, f};
  endfunction
  task chk(input [31:0] e, input [31:0] g, input string n);
    compares++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task bus_wr(input [3:0] a, input [31:0] w);
    addr <= a;
    wdata <= w;
    wr_st <= 1'b1;
    @(posedge clk);
    wr_st <= 1'b0;
    @(posedge clk);
  endtask
  task bus_rd(input [3:0] a);
    addr <= a;
    rd_st <= 1'b1;
    @(posedge clk);
    rd_st <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task wait_pend;
    i = 0;
    while (pend !== 1'b1 && i < 300) begin
      @(posedge clk);
      i++;
    end
    chk(32'h1, {31'h0, pend}, "pending");
  endtask
  task final_report;
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report;
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {wr_st, rd_st, tick, tod_rst, playing, pre_roll, present, run} = 8'h0;
    {addr, wdata, tod} = 60'h0;
    void'($urandom(32'h2F21DBB6));
    step(6);
    rst <= 1'b0;
    pre_roll <= $urandom % 2;
    @(posedge clk);
    bus_wr(4'h2, 32'h51);
    bus_rd(4'h2);
    chk(32'h14, d, "hold");
    bus_wr(4'h2, 32'h50);
    bus_rd(4'h2);
    chk(32'h50, d, "hold");
    bus_rd(4'hF);
    bus_wr(4'h0, 32'h0);
    step(4);
    chk(32'h1, {31'h0, blank}, "blank");
    bus_wr(4'h0, 32'h4);
    v = tc($urandom % 24, $urandom % 60, $urandom % 60, 5'h0);
    tod <= v[28:5];
    tod_rst <= 1'b1;
    step(3);
    tod_rst <= 1'b0;
    step(8);
    chk(v, {3'h0, gen}, "tod");
    chk(32'h0, {31'h0, blank}, "blank");
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    step(6);
    chk(v + 32'h1, {3'h0, gen}, "tick");
    bus_wr(4'h0, 32'h1);
    bus_wr(4'h4, 32'h2);
    step(4);
    chk(32'h0, {3'h0, gen}, "zeros");
    repeat (4) begin
      v = tc($urandom % 24, $urandom % 60, $urandom % 60, $urandom % 30);
      bus_wr(4'h3, v);
      bus_wr(4'h4, 32'h4);
      step(4);
      chk(v, {3'h0, gen}, "jam value");
    end
    bus_wr(4'h3, tc(5'h18, 6'h0, 6'h0, 5'h0));
    bus_wr(4'h4, 32'h4);
    step(4);
    chk(v, {3'h0, gen}, "edit limit");
    bus_wr(4'h1, 32'h3D);
    bus_wr(4'h3, tc(5'h0, 6'h0, 6'h3B, 5'h1D));
    bus_wr(4'h4, 32'h4);
    step(4);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    step(6);
    chk(tc(5'h0, 6'h1, 6'h0, 5'h2), {3'h0, gen}, "drop frame");
    bus_wr(4'h1, 32'h1D);
    bus_wr(4'h0, 32'h5);
    present <= 1'b1;
    run <= 1'b1;
    step(300);
    run <= 1'b0;
    step(60);
    chk({3'h0, rx_time, rx_fnum}, {3'h0, gen}, "follow");
    chk(32'h0, {31'h0, pend}, "pending");
    chk(32'h5, {28'h0, frate}, "file rate");
    v = $urandom;
    bus_wr(4'h6, v);
    step(2);
    chk(v, ub, "user bits");
    bus_wr(4'h5, 32'h1);
    bus_wr(4'h6, ~v);
    bus_wr(4'h5, 32'h7);
    bus_rd(4'h5);
    chk(32'h1, d, "user bit mode");
    bus_wr(4'h5, 32'h0);
    step(2);
    chk(v, ub, "user edit lock");
    bus_wr(4'h0, 32'h1);
    run <= 1'b1;
    i = 0;
    while (!(rx_frame === 1'b1 && rx_fnum === 5'h0) && i < 2000) begin
      @(posedge clk);
      i++;
    end
    run <= 1'b0;
    bus_wr(4'h4, 32'h1);
    step(60);
    chk({3'h0, rx_time, rx_fnum}, {3'h0, gen}, "jam rx");
    v = {3'h0, rx_time, rx_fnum};
    bus_wr(4'h0, 32'h6);
    present <= 1'b0;
    step(6);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    step(6);
    chk(v + 32'h1, {3'h0, gen}, "continue");
    present <= 1'b1;
    bus_wr(4'h2, 32'h2);
    bus_wr(4'h0, 32'h7);
    run <= 1'b1;
    wait_pend;
    chk({31'h0, pre_roll}, {31'h0, cap}, "capture");
    chk(32'h0, {31'h0, rec}, "early record");
    i = 0;
    while (rec !== 1'b1 && i < 400) begin
      @(posedge clk);
      i++;
    end
    chk(32'h1, {31'h0, rec === 1'b1 && i >= 98}, "hold wait");
    run <= 1'b0;
    step(150);
    chk(32'h0, {31'h0, rec}, "stop record");
    run <= 1'b1;
    wait_pend;
    present <= 1'b0;
    step(10);
    chk(32'h0, {31'h0, pend}, "cancel");
    bus_rd(4'h7);
    chk(32'h1, {31'h0, d[29]}, "invalid");
    bus_wr(4'h0, 32'h9);
    step(8);
    chk(32'h0, {31'h0, out_en}, "mute");
    playing <= 1'b1;
    step(8);
    chk(32'h1, {31'h0, out_en}, "unmute");
    final_report;
  end
endmodule // tcg_core_test
